// ---- bench/ptbi_monitor.sv ----
`timescale 1ns/1ps
module ptbi_chk (
  input wire SYS_CLK,
  input wire RESET_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [31:0] PRDATA,
  input wire PREADY,
  input wire PSLVERR,
  input wire OSC_CLK_EN,
  input wire EXTRA_PRESCALE_OPTION,
  input wire OSC_RUN_IN_STOP_OPTION,
  input wire WAIT_MODE,
  input wire STOP_MODE,
  input wire IRQ
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  wire acc = PSEL && PENABLE;
  wire wr = acc && PWRITE;
  wire bad = PADDR != 12'h000 && PADDR != 12'h004 && PADDR != 12'h008;
  wire rdc = acc && !PWRITE && PADDR == 12'h000 && !PSLVERR;
  wire lp = WAIT_MODE || STOP_MODE;
  wire frz = STOP_MODE && !OSC_RUN_IN_STOP_OPTION && !IRQ && !wr;
  chk_lowpwr_refuse: assert property (acc && PADDR == 12'h000 && lp |-> PSLVERR)
    else $error("control open");
  chk_err_cause: assert property (acc && PSLVERR |-> bad || (PADDR == 12'h000 && lp))
    else $error("bad error");
  chk_err_rd_zero: assert property (acc && !PWRITE && PSLVERR |-> PRDATA == 32'h0)
    else $error("error data");
  chk_ack_reads_zero: assert property (rdc |-> !PRDATA[3])
    else $error("ack read");
  chk_irq_on_flag: assert property (rdc && PRDATA[7] && PRDATA[2] |-> IRQ)
    else $error("irq missing");
  chk_irq_cause: assert property ($rose(IRQ) |-> $past(OSC_CLK_EN) || $past(OSC_CLK_EN, 2) || $past(wr))
    else $error("irq cause");
  chk_irq_holds: assert property (IRQ && !wr |=> IRQ)
    else $error("irq dropped");
  chk_stop_frozen: assert property (frz [*3] |=> !IRQ)
    else $error("stop tick");
  cover property ($rose(IRQ));
  cover property (acc && PSLVERR);
  cover property (OSC_RUN_IN_STOP_OPTION && STOP_MODE && $rose(IRQ));
endmodule // ptbi_chk

bind ptbi_timebase ptbi_chk chk_u (.SYS_CLK, .RESET_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
  .PREADY, .PSLVERR, .OSC_CLK_EN, .EXTRA_PRESCALE_OPTION, .OSC_RUN_IN_STOP_OPTION, .WAIT_MODE, .STOP_MODE, .IRQ);

// ---- bench/ptbi_tb.sv ----
`timescale 1ns/1ps
module testbench;
  logic SYS_CLK, RESET_N, PSEL, PENABLE, PWRITE, OSC_CLK_EN, EXTRA_PRESCALE_OPTION;
  logic OSC_RUN_IN_STOP_OPTION, WAIT_MODE, STOP_MODE, PREADY, PSLVERR, IRQ;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rnd;
  logic [32:0] expq[$];
  int fails, compares, ratio[8] = '{32768, 8192, 2048, 128, 64, 32, 16, 8};
  ptbi_timebase dut_u (.SYS_CLK, .RESET_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
    .PSLVERR, .OSC_CLK_EN, .EXTRA_PRESCALE_OPTION, .OSC_RUN_IN_STOP_OPTION, .WAIT_MODE, .STOP_MODE, .IRQ);
  always #50 SYS_CLK = ~SYS_CLK;
  task automatic close_out;
    if (fails == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_irq(input logic exp);
    cmp({32'h0, IRQ}, {32'h0, exp});
  endtask
  // setup, access until ready, release; expected read results go to the queue
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    @(posedge SYS_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    if (!w) expq.push_back(e);
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do @(posedge SYS_CLK); while (PREADY !== 1'b1);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    #1;
  endtask
  task automatic ctl(input logic [7:0] b);
    rnd = $urandom;
    apb(1'b1, 12'h000, {rnd[31:8], b}, 33'h0);
  endtask
  task automatic pulses(input int k);
    repeat (k) begin
      @(posedge SYS_CLK) OSC_CLK_EN <= 1'b1;
      @(posedge SYS_CLK) OSC_CLK_EN <= 1'b0;
      repeat ($urandom_range(1, 0)) @(posedge SYS_CLK);
    end
    repeat (2) @(posedge SYS_CLK);
    #1;
  endtask
  always @(posedge SYS_CLK)
    if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE) cmp({PSLVERR, PRDATA}, expq.pop_front());
  initial begin
    #9_000_000;
    fails++;
    close_out;
  end
  initial begin
    SYS_CLK = 0;
    {RESET_N, PSEL, PENABLE, PWRITE, OSC_CLK_EN, EXTRA_PRESCALE_OPTION} = 0;
    {OSC_RUN_IN_STOP_OPTION, WAIT_MODE, STOP_MODE, PADDR, PWDATA} = 0;
    rnd = $urandom(89);
    repeat (10) @(posedge SYS_CLK);
    RESET_N <= 1'b1;
    repeat (3) @(posedge SYS_CLK);
    apb(0, 12'h000, 0, 0);
    apb(0, 12'h008, 0, 0);
    for (int t = 0; t < 8; t++) begin
      ctl({t[2:0], 4'h6});
      pulses(ratio[t] / 2 - 1);
      cmp_irq(0);
      pulses(1);
      cmp_irq(1);
      ctl({t[2:0], 4'h6});
      cmp_irq(1);
      apb(0, 12'h000, 0, {26'h1, t[2:0], 4'h6});
      ctl({t[2:0], 4'hE});
      cmp_irq(0);
      if (t > 2) begin
        pulses(ratio[t] - 1);
        cmp_irq(0);
        pulses(1);
        cmp_irq(1);
      end
      ctl(8'h08);
    end
    @(posedge SYS_CLK) EXTRA_PRESCALE_OPTION <= 1'b1;
    ctl(8'h76);
    pulses(511);
    cmp_irq(0);
    pulses(1);
    cmp_irq(1);
    ctl(8'h08);
    @(posedge SYS_CLK) EXTRA_PRESCALE_OPTION <= 1'b0;
    ctl(8'h76);
    @(posedge SYS_CLK) WAIT_MODE <= 1'b1;
    apb(0, 12'h000, 0, 33'h100000000);
    ctl(8'h08);
    pulses(4);
    cmp_irq(1);
    @(posedge SYS_CLK) WAIT_MODE <= 1'b0;
    ctl(8'h08);
    ctl(8'h76);
    @(posedge SYS_CLK) STOP_MODE <= 1'b1;
    pulses(6);
    cmp_irq(0);
    @(posedge SYS_CLK) OSC_RUN_IN_STOP_OPTION <= 1'b1;
    pulses(4);
    cmp_irq(1);
    @(posedge SYS_CLK) {STOP_MODE, OSC_RUN_IN_STOP_OPTION} <= 2'b00;
    apb(1, 12'h008, 0, 0);
    cmp_irq(0);
    apb(0, 12'h004, 0, 1);
    apb(1, 12'h004, 1, 0);
    apb(0, 12'h000, 0, 33'h72);
    apb(1, 12'h008, 1, 0);
    cmp_irq(0);
    ctl(8'h00);
    ctl(8'h76);
    pulses(3);
    ctl(8'h00);
    ctl(8'h76);
    pulses(3);
    cmp_irq(0);
    pulses(1);
    cmp_irq(1);
    pulses(8);
    apb(0, 12'h004, 0, 33'h3);
    apb(1, 12'h008, 2, 0);
    cmp_irq(1);
    apb(1, 12'h004, 3, 0);
    cmp_irq(0);
    apb(0, 12'h00C, 0, 33'h100000000);
    close_out;
  end
endmodule // testbench

// ---- common/ptbi_consts.vh ----
`ifndef PTBI_CONSTS_VH
`define PTBI_CONSTS_VH

// register byte addresses
`define PTBI_ADDR_CONTROL 12'h000
`define PTBI_ADDR_STATUS 12'h004
`define PTBI_ADDR_MASK 12'h008
`define PTBI_ADDR_W 12

// timebase_control fields
`define PTBI_CTL_FLAG 7
`define PTBI_CTL_TAP_HI 6
`define PTBI_CTL_TAP_LO 4
`define PTBI_CTL_ACK 3
`define PTBI_CTL_IRQ_EN 2
`define PTBI_CTL_ENABLE 1

// status and mask fields
`define PTBI_ST_TICK 0
`define PTBI_ST_MISSED 1
`define PTBI_ST_W 2

// reset values
`define PTBI_TAP_RESET 3'h0
`define PTBI_ST_RESET 2'h0
`define PTBI_CNT_RESET 22'h000000
`define PTBI_RDATA_RESET 32'h00000000

// divider chain
`define PTBI_CNT_W 22
`define PTBI_IDX_W 5
`define PTBI_PRESCALE_SHIFT 5'h07
`define PTBI_CNT_ONE 22'h000001

// counter bit that rises at half of each tap's period (ratio 2^(bit+1))
`define PTBI_HALF_BIT_0 5'h0E
`define PTBI_HALF_BIT_1 5'h0C
`define PTBI_HALF_BIT_2 5'h0A
`define PTBI_HALF_BIT_3 5'h06
`define PTBI_HALF_BIT_4 5'h05
`define PTBI_HALF_BIT_5 5'h04
`define PTBI_HALF_BIT_6 5'h03
`define PTBI_HALF_BIT_7 5'h02

`endif

// ---- hdl/ptbi_timebase.v ----
`timescale 1ns/1ps
`include "ptbi_consts.vh"

// Operation
// - while disabled the divider counter is held at zero; enabling restarts counting.
// - flag sets each time the half-period counter bit of the selected tap rises.
// - interrupt request goes out when flag and interrupt enable are both set.
// - writing one to acknowledge clears the flag; zero does nothing; reads zero.
// - first event after enable at half period, then every full period.
// - tap select gives ratios 32768, 8192, 2048, 128, 64, 32, 16, 8.
// - extra prescale option multiplies every ratio by 128.
// - event period equals divider value over source clock frequency.
// - divider advances once per oscillator clock enable pulse; the counter itself is clocked by the bus clock.
// - in stop mode counting continues only if the oscillator runs in stop.
// - counting and events continue during wait mode.
// - control register is not reachable by the CPU in wait or stop.
// - reset clears enable and interrupt enable, counter stopped at zero.
module ptbi_timebase (
  input wire SYS_CLK,
  input wire RESET_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  input wire OSC_CLK_EN,
  input wire EXTRA_PRESCALE_OPTION,
  input wire OSC_RUN_IN_STOP_OPTION,
  input wire WAIT_MODE,
  input wire STOP_MODE,
  output wire IRQ
);

  // reset release
  reg rst_meta;
  reg rst_sync;
  wire rst_n;

  // registers
  reg timebase_enable;
  reg timebase_irq_enable;
  reg timebase_irq_flag;
  reg [2:0] divider_tap_select;
  reg missed_tick;
  reg missed_mask;

  // divider chain
  reg [`PTBI_CNT_W-1:0] count;
  wire [`PTBI_CNT_W-1:0] next_count;
  reg [`PTBI_CNT_W-1:0] next_counter;
  wire [`PTBI_IDX_W-1:0] half_bit;
  wire count_step;
  wire tick;
  wire osc_active;

  // bus decode
  wire setup_phase;
  wire access_phase;
  wire low_power;
  wire hit_control;
  wire hit_status;
  wire hit_mask;
  wire mapped;
  wire bus_ok;
  wire wr_control;
  wire wr_status;
  wire wr_mask;
  wire ack_write;
  wire status_w1c_tick;
  wire status_w1c_missed;
  reg [31:0] next_rdata;
  wire clear_flag;

  // next values
  reg next_enable;
  reg [2:0] next_tap;
  reg next_irq_enable;
  reg next_flag;
  reg next_missed;
  reg next_missed_mask;

  // half-period counter bit of each tap
  function [`PTBI_IDX_W-1:0] tap_base_bit;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: tap_base_bit = `PTBI_HALF_BIT_0;
        3'h1: tap_base_bit = `PTBI_HALF_BIT_1;
        3'h2: tap_base_bit = `PTBI_HALF_BIT_2;
        3'h3: tap_base_bit = `PTBI_HALF_BIT_3;
        3'h4: tap_base_bit = `PTBI_HALF_BIT_4;
        3'h5: tap_base_bit = `PTBI_HALF_BIT_5;
        3'h6: tap_base_bit = `PTBI_HALF_BIT_6;
        3'h7: tap_base_bit = `PTBI_HALF_BIT_7;
        default: tap_base_bit = `PTBI_HALF_BIT_0;
      endcase
    end
  endfunction

  // tap index, with optional prescale shift
  function [`PTBI_IDX_W-1:0] tap_half_bit;
    input [2:0] sel;
    input prescale;
    begin
      if (prescale) begin
        tap_half_bit = tap_base_bit(sel) + `PTBI_PRESCALE_SHIFT;
      end else begin
        tap_half_bit = tap_base_bit(sel);
      end
    end
  endfunction

  // address match
  function addr_is;
    input [`PTBI_ADDR_W-1:0] addr;
    input [`PTBI_ADDR_W-1:0] target;
    begin
      addr_is = (addr == target);
    end
  endfunction

  // control register image, acknowledge always reads zero
  function [31:0] control_word;
    input flag;
    input [2:0] tap;
    input irq_en;
    input enable;
    begin
      control_word = `PTBI_RDATA_RESET;
      control_word[`PTBI_CTL_FLAG] = flag;
      control_word[`PTBI_CTL_TAP_HI:`PTBI_CTL_TAP_LO] = tap;
      control_word[`PTBI_CTL_ACK] = 1'b0;
      control_word[`PTBI_CTL_IRQ_EN] = irq_en;
      control_word[`PTBI_CTL_ENABLE] = enable;
    end
  endfunction

  // status and mask share one layout
  function [31:0] event_word;
    input tick_bit;
    input missed_bit;
    begin
      event_word = `PTBI_RDATA_RESET;
      event_word[`PTBI_ST_TICK] = tick_bit;
      event_word[`PTBI_ST_MISSED] = missed_bit;
    end
  endfunction

  // reset synchroniser
  always @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  assign rst_n = rst_sync;

  // oscillator keeps running unless stopped without the option
  assign osc_active = ~STOP_MODE | OSC_RUN_IN_STOP_OPTION;

  // one step per oscillator enable pulse
  assign count_step = timebase_enable & OSC_CLK_EN & osc_active;

  assign next_count = count + `PTBI_CNT_ONE;

  assign half_bit = tap_half_bit(divider_tap_select, EXTRA_PRESCALE_OPTION);

  // rising edge of the half bit: first at 2^k, then every 2^(k+1)
  assign tick = count_step & ~count[half_bit] & next_count[half_bit];

  // divider counter next value
  always @* begin
    next_counter = count;
    if (!timebase_enable) begin
      next_counter = `PTBI_CNT_RESET;
    end else if (count_step) begin
      next_counter = next_count;
    end
  end

  // divider counter
  always @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      count <= `PTBI_CNT_RESET;
    end else begin
      count <= next_counter;
    end
  end

  // bus phases
  assign setup_phase = PSEL & ~PENABLE;
  assign access_phase = PSEL & PENABLE;
  assign low_power = WAIT_MODE | STOP_MODE;

  assign hit_control = addr_is(PADDR, `PTBI_ADDR_CONTROL);
  assign hit_status = addr_is(PADDR, `PTBI_ADDR_STATUS);
  assign hit_mask = addr_is(PADDR, `PTBI_ADDR_MASK);
  assign mapped = hit_control | hit_status | hit_mask;

  // control blocked in low power
  assign bus_ok = mapped & ~(hit_control & low_power);

  // zero wait states
  assign PREADY = access_phase;
  assign PSLVERR = access_phase & ~bus_ok;

  assign wr_control = access_phase & PWRITE & hit_control & ~low_power;
  assign wr_status = access_phase & PWRITE & hit_status;
  assign wr_mask = access_phase & PWRITE & hit_mask;

  assign ack_write = wr_control & PWDATA[`PTBI_CTL_ACK];
  assign status_w1c_tick = wr_status & PWDATA[`PTBI_ST_TICK];
  assign status_w1c_missed = wr_status & PWDATA[`PTBI_ST_MISSED];
  assign clear_flag = ack_write | status_w1c_tick;

  // control field next values
  always @* begin
    next_enable = timebase_enable;
    next_tap = divider_tap_select;
    if (wr_control) begin
      next_enable = PWDATA[`PTBI_CTL_ENABLE];
      next_tap = PWDATA[`PTBI_CTL_TAP_HI:`PTBI_CTL_TAP_LO];
    end
  end

  // control fields
  always @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      timebase_enable <= 1'b0;
      divider_tap_select <= `PTBI_TAP_RESET;
    end else begin
      timebase_enable <= next_enable;
      divider_tap_select <= next_tap;
    end
  end

  // interrupt enable next value, aliased at mask bit 0
  always @* begin
    next_irq_enable = timebase_irq_enable;
    if (wr_control) begin
      next_irq_enable = PWDATA[`PTBI_CTL_IRQ_EN];
    end else if (wr_mask) begin
      next_irq_enable = PWDATA[`PTBI_ST_TICK];
    end
  end

  // interrupt enable
  always @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      timebase_irq_enable <= 1'b0;
    end else begin
      timebase_irq_enable <= next_irq_enable;
    end
  end

  // missed-tick mask next value
  always @* begin
    next_missed_mask = missed_mask;
    if (wr_mask) begin
      next_missed_mask = PWDATA[`PTBI_ST_MISSED];
    end
  end

  // missed-tick mask
  always @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      missed_mask <= 1'b0;
    end else begin
      missed_mask <= next_missed_mask;
    end
  end

  // flag next value: a tick wins over an acknowledge in the same cycle
  always @* begin
    next_flag = timebase_irq_flag;
    if (tick) begin
      next_flag = 1'b1;
    end else if (clear_flag) begin
      next_flag = 1'b0;
    end
  end

  // flag
  always @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      timebase_irq_flag <= 1'b0;
    end else begin
      timebase_irq_flag <= next_flag;
    end
  end

  // missed-tick next value: tick while flag still pending
  always @* begin
    next_missed = missed_tick;
    if (tick & timebase_irq_flag & ~clear_flag) begin
      next_missed = 1'b1;
    end else if (status_w1c_missed) begin
      next_missed = 1'b0;
    end
  end

  // missed tick
  always @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      missed_tick <= 1'b0;
    end else begin
      missed_tick <= next_missed;
    end
  end

  // interrupt request
  assign IRQ = (timebase_irq_flag & timebase_irq_enable) | (missed_tick & missed_mask);

  // read mux
  always @* begin
    next_rdata = `PTBI_RDATA_RESET;
    if (hit_control & ~low_power) begin
      next_rdata = control_word(timebase_irq_flag, divider_tap_select, timebase_irq_enable, timebase_enable);
    end else if (hit_status) begin
      next_rdata = event_word(timebase_irq_flag, missed_tick);
    end else if (hit_mask) begin
      next_rdata = event_word(timebase_irq_enable, missed_mask);
    end
  end

  // read data caught in the setup cycle
  always @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      PRDATA <= `PTBI_RDATA_RESET;
    end else if (setup_phase & ~PWRITE) begin
      PRDATA <= next_rdata;
    end
  end

endmodule // ptbi_timebase
